// File: verilog/dinfd_decoder.sv
/*
 * Digital input function decoder: maps each control input to its assigned
 * function and drives the drive-control effects from it.
 * Assumes inputs synchronous to sys_clk and a plain register port master.
 */
// The implementer's own choices: the placing of the registers and strobed register access.
// Behaviour
// - Both enable right and enable left active blocks the drive.
// - Phase reversal input high inverts the rotating field of the active enable.
// - Each active fixed frequency input adds its table value to the setpoint.
// - Several fixed frequencies sum signed, optionally plus the minimum frequency.
// - Two parameter set bits form the code of the active parameter set.
// - Frequency hold low freezes output frequency during ramps.
// - Voltage disable low switches output voltage off, motor coasts.
// - Quick stop low ramps down using the quick stop time.
// - Fault acknowledge rising edge clears fault, else falling enable does.
// - Thermistor overtemperature warns after one second, trips after two.
// - Under bus control, remote input low returns control to terminals.
// - Jog input high selects the jog frequency value.
// - Motor potentiometer holds like frequency hold, only within min and max.
// - After first watchdog edge, a missing edge within the period trips.
// - Setpoint gates pass analogue setpoints high, force zero low, no shutdown.
`timescale 1ns/100ps
`include "dinfd_cfg.svh"

module dinfd_decoder
	import dinfd_pkg::*;
#(
	parameter int N_IN = 4,
	parameter int TICK_CYCLES = `DINFD_TICK_NS / `DINFD_CLK_NS
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// control terminals and drive state
	input wire logic [N_IN-1:0] din,
	input wire logic ptc_hot,
	input wire logic bus_control,
	input wire logic signed [15:0] setpoint_in,
	input wire logic signed [15:0] actual_freq,
	input wire logic signed [15:0] ain1_in,
	input wire logic signed [15:0] ain2_in,
	// drive control effects
	output logic drive_run,
	output logic dir_left,
	output logic volt_off,
	output logic quick_stop,
	output logic [15:0] quick_stop_time,
	output logic ramp_hold,
	output logic [1:0] active_parameter_set,
	output logic fault_ack_q,
	output logic terminal_ctrl,
	output logic jog_active,
	output logic signed [15:0] setpoint_q,
	output logic signed [15:0] ain1_q,
	output logic signed [15:0] ain2_q,
	output logic no_shutdown,
	// protection
	output logic thermal_warn,
	output logic thermal_trip_q,
	output logic watchdog_trip_error_q
);

	// function codes this block acts upon; all others are inert
	localparam logic [31:0] FN_IMPL = 32'h001FFFFE;

	// configuration registers
	logic [4:0] func_q [N_IN];
	dinfd_freq_t fixed_frequency_table_q [4];
	dinfd_freq_t minimum_frequency_q;
	dinfd_freq_t maximum_frequency_q;
	dinfd_freq_t absolute_minimum_frequency_q;
	dinfd_freq_t jog_frequency_value_q;
	logic [15:0] quick_stop_time_q;
	logic [15:0] watchdog_period_q;
	logic [1:0] ctrl_q;

	// decoded functions
	logic [31:0] sel [N_IN];
	logic [31:0] asg;
	logic [31:0] lvl;
	logic [31:0] lvl_prev_q;
	logic en_r;
	logic en_l;
	logic en_any;
	logic en_any_prev_q;
	logic ack_pulse;
	logic ptc_active;
	logic wd_edge;
	logic wd_armed_q;
	logic tick;
	logic [31:0] tick_cnt_q;
	logic [15:0] ptc_ms;
	logic [15:0] wd_ms;
	logic signed [18:0] fsum;
	logic any_fix;
	logic pot_in_range;

	// one-hot code per input
	for (genvar i = 0; i < N_IN; i++) begin : g_sel
		assign sel[i] = 32'h00000001 << func_q[i];
	end

	always_comb begin
		asg = 32'h00000000;
		lvl = 32'h00000000;
		for (int i = 0; i < N_IN; i++) begin
			asg = asg | sel[i];
			if (din[i]) begin
				lvl = lvl | sel[i];
			end
		end
		asg = asg & FN_IMPL;
		lvl = lvl & FN_IMPL;
	end

	// register writes
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			for (int i = 0; i < N_IN; i++) begin
				func_q[i] <= 5'h00;
			end
			for (int j = 0; j < 4; j++) begin
				fixed_frequency_table_q[j] <= `DINFD_RST_FREQ;
			end
			minimum_frequency_q <= `DINFD_RST_FREQ;
			maximum_frequency_q <= `DINFD_RST_MAX_FREQ;
			absolute_minimum_frequency_q <= `DINFD_RST_FREQ;
			jog_frequency_value_q <= `DINFD_RST_FREQ;
			quick_stop_time_q <= `DINFD_RST_QSTOP;
			watchdog_period_q <= `DINFD_RST_WDOG;
			ctrl_q <= `DINFD_RST_CTRL;
		end else if (reg_wr) begin
			for (int i = 0; i < N_IN; i++) begin
				if (reg_addr == `DINFD_ADDR_FUNC_BASE + 8'(4 * i)) begin
					func_q[i] <= reg_wdata[4:0];
				end
			end
			for (int j = 0; j < 4; j++) begin
				if (reg_addr == `DINFD_ADDR_FIX_BASE + 8'(4 * j)) begin
					fixed_frequency_table_q[j] <= reg_wdata[15:0];
				end
			end
			unique case (reg_addr)
				`DINFD_ADDR_MIN_FREQ: minimum_frequency_q <= reg_wdata[15:0];
				`DINFD_ADDR_MAX_FREQ: maximum_frequency_q <= reg_wdata[15:0];
				`DINFD_ADDR_ABS_MIN: absolute_minimum_frequency_q <= reg_wdata[15:0];
				`DINFD_ADDR_JOG_FREQ: jog_frequency_value_q <= reg_wdata[15:0];
				`DINFD_ADDR_QSTOP_TIME: quick_stop_time_q <= reg_wdata[15:0];
				`DINFD_ADDR_WDOG_PERIOD: watchdog_period_q <= reg_wdata[15:0];
				`DINFD_ADDR_CTRL: ctrl_q <= reg_wdata[1:0];
				default: ;
			endcase
		end
	end

	// register reads, data in the cycle after the strobe, zero when unmapped
	always_ff @(posedge sys_clk) begin
		if (!reset_n || !reg_rd) begin
			reg_rdata <= 32'h00000000;
		end else begin
			reg_rdata <= 32'h00000000;
			for (int i = 0; i < N_IN; i++) begin
				if (reg_addr == `DINFD_ADDR_FUNC_BASE + 8'(4 * i)) begin
					reg_rdata <= {27'h0000000, func_q[i]};
				end
			end
			for (int j = 0; j < 4; j++) begin
				if (reg_addr == `DINFD_ADDR_FIX_BASE + 8'(4 * j)) begin
					reg_rdata <= {16'h0000, fixed_frequency_table_q[j]};
				end
			end
			unique case (reg_addr)
				`DINFD_ADDR_MIN_FREQ: reg_rdata <= {16'h0000, minimum_frequency_q};
				`DINFD_ADDR_MAX_FREQ: reg_rdata <= {16'h0000, maximum_frequency_q};
				`DINFD_ADDR_ABS_MIN: reg_rdata <= {16'h0000, absolute_minimum_frequency_q};
				`DINFD_ADDR_JOG_FREQ: reg_rdata <= {16'h0000, jog_frequency_value_q};
				`DINFD_ADDR_QSTOP_TIME: reg_rdata <= {16'h0000, quick_stop_time_q};
				`DINFD_ADDR_WDOG_PERIOD: reg_rdata <= {16'h0000, watchdog_period_q};
				`DINFD_ADDR_CTRL: reg_rdata <= {30'h00000000, ctrl_q};
				`DINFD_ADDR_STATUS: reg_rdata <= {24'h000000, wd_armed_q,
					watchdog_trip_error_q, thermal_trip_q, thermal_warn,
					active_parameter_set, dir_left, drive_run};
				default: ;
			endcase
		end
	end

	// enables and direction
	assign en_r = lvl[FN_EN_RIGHT];
	assign en_l = lvl[FN_EN_LEFT];
	assign en_any = en_r | en_l;
	assign drive_run = (en_r ^ en_l) & ~volt_off & ~thermal_trip_q & ~watchdog_trip_error_q;
	assign dir_left = en_l ^ lvl[FN_REVERSE];

	assign active_parameter_set = {lvl[FN_PSET_B1], lvl[FN_PSET_B0]};
	assign volt_off = asg[FN_VOLT_OFF] & ~lvl[FN_VOLT_OFF];
	assign quick_stop = asg[FN_QSTOP] & ~lvl[FN_QSTOP];
	assign quick_stop_time = quick_stop_time_q;
	assign terminal_ctrl = ~bus_control | (asg[FN_REMOTE] & ~lvl[FN_REMOTE]);
	assign jog_active = lvl[FN_JOG];

	assign pot_in_range = (actual_freq >= minimum_frequency_q) &&
		(actual_freq <= maximum_frequency_q);
	assign ramp_hold = (asg[FN_FREQ_HOLD] & ~lvl[FN_FREQ_HOLD]) |
		(asg[FN_MOTOR_POT] & ~lvl[FN_MOTOR_POT] & pot_in_range);

	always_comb begin
		fsum = 19'(setpoint_in);
		any_fix = 1'b0;
		for (int j = 0; j < 4; j++) begin
			if (lvl[FN_FIX1 + j]) begin
				fsum = fsum + 19'(fixed_frequency_table_q[j]);
				any_fix = 1'b1;
			end
		end
		if (any_fix && ctrl_q[`DINFD_CTRL_ADD_MIN]) begin
			fsum = fsum + 19'(minimum_frequency_q);
		end
	end

	// setpoint and gated analogue outputs
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			setpoint_q <= 16'h0000;
			ain1_q <= 16'h0000;
			ain2_q <= 16'h0000;
		end else begin
			setpoint_q <= jog_active ? jog_frequency_value_q : fsum[15:0];
			ain1_q <= (asg[FN_AIN1_GATE] & ~lvl[FN_AIN1_GATE]) ? 16'h0000 : ain1_in;
			ain2_q <= (asg[FN_AIN2_GATE] & ~lvl[FN_AIN2_GATE]) ? 16'h0000 : ain2_in;
		end
	end
	assign no_shutdown = minimum_frequency_q > absolute_minimum_frequency_q;

	// previous levels for edge detection
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			lvl_prev_q <= 32'h00000000;
			en_any_prev_q <= 1'b0;
		end else begin
			lvl_prev_q <= lvl;
			en_any_prev_q <= en_any;
		end
	end

	// acknowledge by edge or by enable release
	assign ack_pulse = asg[FN_FAULT_ACK] ?
		(lvl[FN_FAULT_ACK] & ~lvl_prev_q[FN_FAULT_ACK]) :
		(ctrl_q[`DINFD_CTRL_AUTO_ACK] & en_any_prev_q & ~en_any);

	// registered acknowledge pulse
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			fault_ack_q <= 1'b0;
		end else begin
			fault_ack_q <= ack_pulse;
		end
	end

	// millisecond timebase
	always_ff @(posedge sys_clk) begin
		if (!reset_n || tick) begin
			tick_cnt_q <= 32'h00000000;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h00000001;
		end
	end
	assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));

	// thermistor persistence, dedicated terminal or assigned input low
	assign ptc_active = ptc_hot | (asg[FN_THERMISTOR] & ~lvl[FN_THERMISTOR]);

	dinfd_timer u_ptc_timer (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.tick(tick),
		.run(ptc_active),
		.clear(1'b0),
		.count_q(ptc_ms)
	);

	assign thermal_warn = ptc_ms >= 16'(`DINFD_PTC_WARN_MS);

	// trip after two seconds, held until acknowledged
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			thermal_trip_q <= 1'b0;
		end else if (ptc_ms >= 16'(`DINFD_PTC_TRIP_MS)) begin
			thermal_trip_q <= 1'b1;
		end else if (ack_pulse) begin
			thermal_trip_q <= 1'b0;
		end
	end

	// watchdog edge and arming
	assign wd_edge = lvl[FN_WATCHDOG] & ~lvl_prev_q[FN_WATCHDOG];

	always_ff @(posedge sys_clk) begin
		if (!reset_n || !asg[FN_WATCHDOG]) begin
			wd_armed_q <= 1'b0;
		end else if (wd_edge) begin
			wd_armed_q <= 1'b1;
		end
	end

	dinfd_timer u_wd_timer (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.tick(tick),
		.run(wd_armed_q),
		.clear(wd_edge),
		.count_q(wd_ms)
	);

	// missing edge trips, trip wins over acknowledge
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			watchdog_trip_error_q <= 1'b0;
		end else if (wd_armed_q && !wd_edge && wd_ms >= watchdog_period_q) begin
			watchdog_trip_error_q <= 1'b1;
		end else if (ack_pulse) begin
			watchdog_trip_error_q <= 1'b0;
		end
	end

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	sequence s_ack_edge;
		asg[FN_FAULT_ACK] && lvl[FN_FAULT_ACK] && !lvl_prev_q[FN_FAULT_ACK];
	endsequence

	sequence s_ptc_long;
		ptc_active && ptc_ms >= 16'(`DINFD_PTC_TRIP_MS);
	endsequence

	AST_BOTH_EN_BLOCK: assert property (en_r && en_l |-> !drive_run)
		else $error("both enables did not block");
	AST_REVERSE_DIR: assert property (en_r && !en_l && lvl[FN_REVERSE] |-> dir_left)
		else $error("reversal did not turn field");
	AST_PSET_CODE: assert property (func_q[0] == FN_PSET_B0 && din[0] |->
		active_parameter_set[0])
		else $error("parameter set code wrong");
	AST_VOLT_OFF: assert property (asg[FN_VOLT_OFF] && !lvl[FN_VOLT_OFF] |-> !drive_run)
		else $error("voltage disable did not stop output");
	AST_ACK_PULSE: assert property (s_ack_edge |=> fault_ack_q ##1 !fault_ack_q)
		else $error("acknowledge pulse missing");
	AST_PTC_TRIP: assert property (s_ptc_long |=> thermal_trip_q && thermal_warn)
		else $error("thermistor trip missing");
	AST_PTC_EARLY: assert property ($rose(thermal_trip_q) |-> $past(ptc_ms) >= 16'(`DINFD_PTC_TRIP_MS))
		else $error("thermistor tripped early");
	AST_REMOTE: assert property (!bus_control |-> terminal_ctrl)
		else $error("terminal control lost");
	AST_WD_IDLE: assert property (!wd_armed_q && !watchdog_trip_error_q |=>
		!watchdog_trip_error_q)
		else $error("watchdog tripped unarmed");
	AST_AIN_GATE: assert property (asg[FN_AIN1_GATE] && !lvl[FN_AIN1_GATE] |=> ain1_q == 16'h0000)
		else $error("analogue gate did not force zero");
	AST_JOG: assert property (jog_active |=> setpoint_q == $past(jog_frequency_value_q))
		else $error("jog frequency not selected");

endmodule : dinfd_decoder

// File: verilog/dinfd_cfg.svh
/*
 * Register offsets, field positions, reset values and timing figures of the
 * digital input function decoder.
 * Assumes a 100 MHz control clock and a byte-addressed plain register port.
 */
`ifndef DINFD_CFG_SVH
`define DINFD_CFG_SVH

// register byte offsets
`define DINFD_ADDR_FUNC_BASE 8'h00
`define DINFD_ADDR_FIX_BASE 8'h10
`define DINFD_ADDR_MIN_FREQ 8'h20
`define DINFD_ADDR_MAX_FREQ 8'h24
`define DINFD_ADDR_ABS_MIN 8'h28
`define DINFD_ADDR_JOG_FREQ 8'h2C
`define DINFD_ADDR_QSTOP_TIME 8'h30
`define DINFD_ADDR_WDOG_PERIOD 8'h34
`define DINFD_ADDR_CTRL 8'h38
`define DINFD_ADDR_STATUS 8'h3C

// control register fields
`define DINFD_CTRL_AUTO_ACK 0
`define DINFD_CTRL_ADD_MIN 1

// reset values
`define DINFD_RST_FREQ 16'h0000
`define DINFD_RST_MAX_FREQ 16'h01F4
`define DINFD_RST_QSTOP 16'h000A
`define DINFD_RST_WDOG 16'h0064
`define DINFD_RST_CTRL 2'h1

// timing: clock period, timer tick, thermistor delays in ticks (1 ms)
`define DINFD_CLK_NS 10
`define DINFD_TICK_NS 1000000
`define DINFD_PTC_WARN_MS 1000
`define DINFD_PTC_TRIP_MS 2000

`endif

// File: verilog/dinfd_pkg.sv
/*
 * Types of the digital input function decoder.
 * Assumes the constants of dinfd_cfg.svh alongside.
 */
package dinfd_pkg;

	// signed frequency in the drive's setpoint unit
	typedef logic signed [15:0] dinfd_freq_t;

	// function codes that an input may carry
	typedef enum logic [4:0] {
		FN_NONE = 5'h00,
		FN_EN_RIGHT = 5'h01,
		FN_EN_LEFT = 5'h02,
		FN_REVERSE = 5'h03,
		FN_FIX1 = 5'h04,
		FN_PSET_B0 = 5'h08,
		FN_FREQ_HOLD = 5'h09,
		FN_VOLT_OFF = 5'h0A,
		FN_QSTOP = 5'h0B,
		FN_FAULT_ACK = 5'h0C,
		FN_THERMISTOR = 5'h0D,
		FN_REMOTE = 5'h0E,
		FN_JOG = 5'h0F,
		FN_MOTOR_POT = 5'h10,
		FN_PSET_B1 = 5'h11,
		FN_WATCHDOG = 5'h12,
		FN_AIN1_GATE = 5'h13,
		FN_AIN2_GATE = 5'h14
	} dinfd_fn_t;

endpackage : dinfd_pkg

// File: verilog/dinfd_timer.sv
/*
 * Millisecond persistence timer: counts ticks while run is high, restarts on clear.
 * Assumes tick is a one-cycle pulse in the sys_clk domain.
 */
`timescale 1ns/100ps

module dinfd_timer (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// control
	input wire logic tick,
	input wire logic run,
	input wire logic clear,
	// elapsed time
	output logic [15:0] count_q
);

	// saturating count of ticks, held at zero when idle
	always_ff @(posedge sys_clk) begin
		if (!reset_n || clear || !run) begin
			count_q <= 16'h0000;
		end else if (tick && count_q != 16'hFFFF) begin
			count_q <= count_q + 16'h0001;
		end
	end

endmodule : dinfd_timer

// File: dv/dinfd_terminals.sv
/*
 * Control terminal model: switch levels on din, and a controller pulsing the
 * watchdog input on the top terminal.
 * Assumes the testbench sets the levels and the pulse spacing in sys_clk cycles.
 */
`timescale 1ns/100ps

module dinfd_terminals (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// switch levels and pulse control
	input wire logic [3:0] lvl,
	input wire logic wd_on,
	input wire logic [7:0] wd_gap,
	// terminals
	output logic [3:0] din
);
	logic [7:0] cnt_q;
	logic pulse_q;

	always_ff @(posedge sys_clk) begin
		if (!reset_n || !wd_on) begin
			cnt_q <= 8'h00;
			pulse_q <= 1'b0;
		end else begin
			cnt_q <= (cnt_q == wd_gap) ? 8'h00 : cnt_q + 8'h01;
			pulse_q <= (cnt_q < 8'h04);
		end
	end

	// top terminal carries the pulse while the controller runs
	assign din = wd_on ? {pulse_q, lvl[2:0]} : lvl;
endmodule : dinfd_terminals

// File: dv/tb.sv
/*
 * Testbench of the digital input function decoder: register tasks and
 * terminal scenarios with expected values.
 * Assumes a 1 ms tick shortened to 10 cycles.
 */
`timescale 1ns/100ps
`include "dinfd_cfg.svh"

module tb
	import dinfd_pkg::*;
;
	logic sys_clk, reset_n, reg_wr, reg_rd, ptc_hot, bus_control, wd_on;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rv;
	logic [3:0] lvl, din, lo_out;
	logic signed [15:0] setpoint_in, actual_freq, ain1_in, ain2_in;
	logic signed [15:0] setpoint_q, ain1_q, ain2_q;
	logic [15:0] quick_stop_time;
	logic [1:0] active_parameter_set;
	logic drive_run, dir_left, volt_off, quick_stop, ramp_hold, fault_ack_q;
	logic terminal_ctrl, jog_active, no_shutdown, thermal_warn, thermal_trip_q;
	logic watchdog_trip_error_q;
	int num_errors = 0;
	int n_tests = 0;
	dinfd_fn_t lo_fn [4] = '{FN_FREQ_HOLD, FN_VOLT_OFF, FN_QSTOP, FN_REMOTE};

	dinfd_decoder #(.N_IN(4), .TICK_CYCLES(10)) u_dinfd_decoder (
		.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.din(din), .ptc_hot(ptc_hot), .bus_control(bus_control),
		.setpoint_in(setpoint_in), .actual_freq(actual_freq), .ain1_in(ain1_in),
		.ain2_in(ain2_in), .drive_run(drive_run), .dir_left(dir_left),
		.volt_off(volt_off), .quick_stop(quick_stop), .quick_stop_time(quick_stop_time),
		.ramp_hold(ramp_hold), .active_parameter_set(active_parameter_set),
		.fault_ack_q(fault_ack_q), .terminal_ctrl(terminal_ctrl), .jog_active(jog_active),
		.setpoint_q(setpoint_q), .ain1_q(ain1_q), .ain2_q(ain2_q),
		.no_shutdown(no_shutdown), .thermal_warn(thermal_warn),
		.thermal_trip_q(thermal_trip_q), .watchdog_trip_error_q(watchdog_trip_error_q));

	dinfd_terminals u_dinfd_terminals (.sys_clk(sys_clk), .reset_n(reset_n),
		.lvl(lvl), .wd_on(wd_on), .wd_gap(8'h13), .din(din));

	// low-active effects in the order of lo_fn
	assign lo_out = {terminal_ctrl, quick_stop, volt_off, ramp_hold};

	// clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		rv = reg_rdata;
	endtask : rd

	task automatic set_fn(input int i, input logic [4:0] code);
		wr(8'(`DINFD_ADDR_FUNC_BASE + 4 * i), {27'h0, code});
	endtask : set_fn

	task automatic set_lvl(input logic [3:0] v);
		@(posedge sys_clk);
		lvl <= v;
		#1;
	endtask : set_lvl

	// hang guard
	initial begin
		repeat (60000) @(posedge sys_clk);
		num_errors++;
		stop_test();
	end

	// main sequence
	initial begin
		reset_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0;
		ptc_hot = 1'b0; bus_control = 1'b0; wd_on = 1'b0; lvl = 4'h0;
		setpoint_in = 16'h0064; actual_freq = 16'h0010; ain1_in = 16'h0123; ain2_in = 16'hFF00;
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		rd(`DINFD_ADDR_QSTOP_TIME); check("qstop_rst", rv[15:0], 16'h000A);
		check("qstop_port", quick_stop_time, 16'h000A);
		rd(`DINFD_ADDR_WDOG_PERIOD); check("wdog_rst", rv[15:0], 16'h0064);
		rd(`DINFD_ADDR_CTRL); check("ctrl_rst", rv[15:0], 16'h0001);
		rd(8'h40); check("unmapped", rv[15:0], 16'h0000);
		$display("test reset done");
		set_fn(0, FN_EN_RIGHT); set_fn(1, FN_EN_LEFT); set_fn(2, FN_REVERSE);
		set_fn(3, FN_FIX1);
		set_lvl(4'h1); check("run_right", {drive_run, dir_left}, 16'h0002);
		set_lvl(4'h5); check("dir_rev_r", dir_left, 1'b1);
		set_lvl(4'h6); check("dir_rev_l", dir_left, 1'b0);
		set_lvl(4'h3); check("both_en", drive_run, 1'b0);
		wr(`DINFD_ADDR_FIX_BASE, 32'h0032);
		set_lvl(4'h9); cyc(2); check("fix1", setpoint_q, 16'h0096);
		set_lvl(4'h1); cyc(2); check("fix_off", setpoint_q, 16'h0064);
		set_fn(2, 5'h05); wr(8'(`DINFD_ADDR_FIX_BASE + 4), 32'h0000FFF6);
		wr(`DINFD_ADDR_MIN_FREQ, 32'h5); wr(`DINFD_ADDR_CTRL, 32'h3);
		set_lvl(4'hD); cyc(2); check("fix_sum", setpoint_q, 16'h0091);
		wr(`DINFD_ADDR_CTRL, 32'h1);
		$display("test enables done");
		bus_control <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			set_fn(0, lo_fn[k]);
			set_lvl(4'h1); check("low_fn_hi", lo_out[k], 1'b0);
			set_lvl(4'h0); check("low_fn_lo", lo_out[k], 1'b1);
		end
		set_fn(0, FN_PSET_B0); set_fn(1, FN_PSET_B1);
		for (int p = 0; p < 4; p++) begin
			set_lvl(4'(p)); check("pset", active_parameter_set, 16'(p));
		end
		set_fn(1, FN_NONE); set_fn(2, FN_NONE); set_fn(3, FN_NONE);
		set_fn(0, FN_JOG); wr(`DINFD_ADDR_JOG_FREQ, 32'h19);
		set_lvl(4'h1); cyc(2); check("jog", setpoint_q, 16'h0019);
		check("jog_on", jog_active, 1'b1);
		set_fn(0, FN_MOTOR_POT); set_lvl(4'h0);
		check("pot_in", ramp_hold, 1'b1);
		@(posedge sys_clk); actual_freq <= 16'h0200;
		#1 check("pot_max", ramp_hold, 1'b0);
		@(posedge sys_clk); actual_freq <= 16'h0002;
		#1 check("pot_min", ramp_hold, 1'b0);
		set_fn(0, FN_AIN1_GATE); set_fn(1, FN_AIN2_GATE);
		set_lvl(4'h0); cyc(2); check("gate_off", ain1_q | ain2_q, 16'h0000);
		set_lvl(4'h3); cyc(2); check("gate1_on", ain1_q, 16'h0123);
		check("gate2_on", ain2_q, 16'hFF00);
		check("no_shut", no_shutdown, 1'b1);
		wr(`DINFD_ADDR_ABS_MIN, 32'h8); cyc(1); check("shut", no_shutdown, 1'b0);
		set_fn(0, 5'h15); set_fn(1, 5'h1F);
		set_lvl(4'h0); check("resv_lo", {lo_out, drive_run}, 16'h0000);
		set_lvl(4'h3); check("resv_hi", {lo_out, drive_run}, 16'h0000);
		$display("test functions done");
		set_fn(0, FN_FAULT_ACK); set_lvl(4'h0);
		@(posedge sys_clk); ptc_hot <= 1'b1;
		cyc(9900); check("warn_early", thermal_warn, 1'b0);
		cyc(200); check("warn", {thermal_warn, thermal_trip_q}, 16'h0002);
		cyc(9700); check("trip_early", thermal_trip_q, 1'b0);
		cyc(220); check("trip", thermal_trip_q, 1'b1);
		@(posedge sys_clk); ptc_hot <= 1'b0;
		set_lvl(4'h1); cyc(1); check("ack", fault_ack_q, 1'b1);
		cyc(1); check("ack_end", {fault_ack_q, thermal_trip_q}, 16'h0000);
		$display("test thermistor done");
		wr(`DINFD_ADDR_WDOG_PERIOD, 32'h5); set_fn(3, FN_WATCHDOG);
		@(posedge sys_clk); wd_on <= 1'b1;
		cyc(300); check("wd_fed", watchdog_trip_error_q, 1'b0);
		@(posedge sys_clk); wd_on <= 1'b0;
		cyc(20); check("wd_early", watchdog_trip_error_q, 1'b0);
		cyc(70); check("wd_trip", watchdog_trip_error_q, 1'b1);
		rd(`DINFD_ADDR_STATUS); check("wd_status", 16'(rv[6]), 16'h0001);
		set_fn(3, FN_NONE); set_fn(0, FN_EN_RIGHT);
		set_lvl(4'h0); cyc(1);
		check("auto_ack", {fault_ack_q, watchdog_trip_error_q}, 16'h0002);
		$display("test watchdog done");
		stop_test();
	end
endmodule : tb
